// ===== rtl/sfts_consts.svh
// constants of the fifo data-set and temperature readout block
`ifndef SFTS_CONSTS_SVH
`define SFTS_CONSTS_SVH
`define SFTS_CLK_HZ 125000000
`define SFTS_TEMP_HZ_LO 13
`define SFTS_TEMP_HZ_MID 26
`define SFTS_TEMP_HZ_MAX 52
`define SFTS_ADDR_TEMP_L 8'h20
`define SFTS_ADDR_TEMP_H 8'h21
`define SFTS_TEMP_RST 16'h0000
`define SFTS_RDATA_RST 8'h00
`define SFTS_ODR_PD 4'h0
`define SFTS_ODR_13 4'h1
`define SFTS_ODR_26 4'h2
`define SFTS_ST_OFF 2'h0
`define SFTS_ST_POS 2'h1
`define SFTS_XL_ST_NEG 2'h2
`define SFTS_G_ST_NEG 2'h3
`define SFTS_DEC_OFF 3'h0
`define SFTS_ST_FORCE 16'h0100
`endif

// ===== rtl/sfts_pkg.sv
// types and helper functions of the fifo data-set and temperature block
`include "sfts_consts.svh"
package sfts_pkg;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } sfts_axes_t;
  typedef enum logic [1:0] {SFTS_SET1, SFTS_SET2, SFTS_SET3} sfts_set_t;
  typedef enum logic [1:0] {
    SFTS_TR_OFF, SFTS_TR_13, SFTS_TR_26, SFTS_TR_52
  } sfts_trate_t;
  // b[0] is byte 1 of the frame
  typedef struct packed {
    sfts_set_t set;
    logic [5:0][7:0] b;
  } sfts_frame_t;
  typedef struct packed {
    logic [3:0] accel_odr;
    logic accel_low_power;
    logic [3:0] gyro_odr;
    logic gyro_low_power;
    logic high_only;
    logic [2:0] gyro_set_decimation;
    logic [2:0] accel_set_decimation;
    logic [2:0] third_set_decimation;
    logic stamp_steps_store_en;
    logic step_trigger_select;
    logic temp_store_en;
    logic temp_flag_to_irq2;
    logic byte_order_swap;
    logic [1:0] accel_selftest_select;
    logic [1:0] gyro_selftest_select;
  } sfts_cfg_t;

  // decimation code to factor, zero means set not stored
  function automatic logic [5:0] sfts_dec_factor(input logic [2:0] code);
    case (code)
      3'h1: sfts_dec_factor = 6'h01;
      3'h2: sfts_dec_factor = 6'h02;
      3'h3: sfts_dec_factor = 6'h03;
      3'h4: sfts_dec_factor = 6'h04;
      3'h5: sfts_dec_factor = 6'h08;
      3'h6: sfts_dec_factor = 6'h10;
      3'h7: sfts_dec_factor = 6'h20;
      default: sfts_dec_factor = 6'h00;
    endcase
  endfunction

  // lowest set still due in a mask
  function automatic sfts_set_t sfts_first_due(input logic [2:0] m);
    if (m[0]) sfts_first_due = SFTS_SET1;
    else if (m[1]) sfts_first_due = SFTS_SET2;
    else sfts_first_due = SFTS_SET3;
  endfunction

  // sensor output under self-test: physical input plus test force
  function automatic logic [15:0] sfts_st_apply(input logic [15:0] raw,
      input logic [1:0] sel, input logic [1:0] neg);
    if (sel == `SFTS_ST_POS) sfts_st_apply = raw + `SFTS_ST_FORCE;
    else if (sel == neg) sfts_st_apply = raw - `SFTS_ST_FORCE;
    else sfts_st_apply = raw;
  endfunction
endpackage

// ===== rtl/sfts_frame_pack.sv
// builds one six-byte fifo frame for the selected data set
`timescale 1ns/10ps
module sfts_frame_pack (
  input wire sfts_pkg::sfts_set_t set_sel,
  input wire sfts_pkg::sfts_cfg_t cfg,
  input wire sfts_pkg::sfts_axes_t gyro,
  input wire sfts_pkg::sfts_axes_t accel,
  input wire logic [23:0] stamp,
  input wire logic [15:0] steps,
  input wire logic [15:0] temp,
  output sfts_pkg::sfts_frame_t frame
);
  // byte layout per data set; unused bytes read zero
  always_comb begin
    frame = '0;
    frame.set = set_sel;
    unique case (set_sel)
      sfts_pkg::SFTS_SET1: begin
        if (cfg.high_only) begin
          frame.b = {accel.z[15:8], gyro.z[15:8], accel.y[15:8],
                     gyro.y[15:8], accel.x[15:8], gyro.x[15:8]};
        end else begin
          frame.b = {gyro.z, gyro.y, gyro.x};
        end
      end
      sfts_pkg::SFTS_SET2: frame.b = {accel.z, accel.y, accel.x};
      sfts_pkg::SFTS_SET3: begin
        if (cfg.stamp_steps_store_en) begin
          frame.b = {steps, stamp[7:0], 8'h00, stamp[23:8]};
        end else begin
          frame.b = {16'h0000, temp, 16'h0000};
        end
      end
    endcase
  end
endmodule // sfts_frame_pack

// ===== rtl/sfts_temp_rate.sv
// temperature sample rate selection and sample tick divider
`timescale 1ns/10ps
`include "sfts_consts.svh"
module sfts_temp_rate #(
  parameter int DIV_LO = 1,
  parameter int DIV_MID = 1,
  parameter int DIV_MAX = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire sfts_pkg::sfts_cfg_t cfg,
  output sfts_pkg::sfts_trate_t rate,
  output logic tick
);
  logic [23:0] cnt;
  logic [23:0] lim;
  logic a_pd;
  logic g_pd;
  sfts_pkg::sfts_trate_t a_lone;
  sfts_pkg::sfts_trate_t g_lone;
  sfts_pkg::sfts_trate_t a_r;
  sfts_pkg::sfts_trate_t g_r;

  // odr code to temperature rate, saturated at the top rate
  function automatic sfts_pkg::sfts_trate_t odr_rate(input logic [3:0] o);
    if (o == `SFTS_ODR_13) odr_rate = sfts_pkg::SFTS_TR_13;
    else if (o == `SFTS_ODR_26) odr_rate = sfts_pkg::SFTS_TR_26;
    else odr_rate = sfts_pkg::SFTS_TR_52;
  endfunction

  // rate selection from the two sensors' power states
  assign a_pd = cfg.accel_odr == `SFTS_ODR_PD;
  assign g_pd = cfg.gyro_odr == `SFTS_ODR_PD;
  assign a_r = odr_rate(cfg.accel_odr);
  assign g_r = odr_rate(cfg.gyro_odr);
  assign a_lone = (a_r == sfts_pkg::SFTS_TR_26 && !cfg.accel_low_power) ?
                  sfts_pkg::SFTS_TR_52 : a_r;
  assign g_lone = (g_r != sfts_pkg::SFTS_TR_52 && !cfg.gyro_low_power) ?
                  sfts_pkg::SFTS_TR_52 : g_r;
  assign rate = (a_pd && g_pd) ? sfts_pkg::SFTS_TR_OFF :
                g_pd ? a_lone : a_pd ? g_lone :
                !cfg.gyro_low_power ? sfts_pkg::SFTS_TR_52 :
                (a_r > g_r) ? a_r : g_r;
  assign lim = (rate == sfts_pkg::SFTS_TR_13) ? 24'(DIV_LO) :
               (rate == sfts_pkg::SFTS_TR_26) ? 24'(DIV_MID) : 24'(DIV_MAX);
  assign tick = rate != sfts_pkg::SFTS_TR_OFF && cnt >= lim - 24'h000001;

  // free divider, held clear while the sensor is off
  always_ff @(posedge clk) begin
    if (rst || rate == sfts_pkg::SFTS_TR_OFF || tick) cnt <= 24'h000000;
    else cnt <= cnt + 24'h000001;
  end
endmodule // sfts_temp_rate

// ===== rtl/sfts_top.sv
// fifo data-set packing, temperature output and self-test sum block
//------------------------------------------------------------------
//------------------------------------------------------------------
`timescale 1ns/10ps
`include "sfts_consts.svh"
module sfts_top #(
  parameter int TEMP_DIV_LO = `SFTS_CLK_HZ / `SFTS_TEMP_HZ_LO,
  parameter int TEMP_DIV_MID = `SFTS_CLK_HZ / `SFTS_TEMP_HZ_MID,
  parameter int TEMP_DIV_MAX = `SFTS_CLK_HZ / `SFTS_TEMP_HZ_MAX
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire sfts_pkg::sfts_cfg_t CFG,
  input wire sfts_pkg::sfts_axes_t GYRO_RAW,
  input wire sfts_pkg::sfts_axes_t ACCEL_RAW,
  input wire logic [15:0] TEMP_RAW,
  input wire logic [23:0] TIME_STAMP,
  input wire logic [15:0] STEP_COUNT,
  input wire logic FIFO_TRIG,
  input wire logic STEP_DET,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic FRAME_VALID,
  input wire logic FRAME_READY,
  output sfts_pkg::sfts_frame_t FRAME,
  output logic TEMP_SENSOR_ON,
  output logic TEMP_SAMPLE_AVAILABLE,
  output logic SECOND_IRQ_PIN,
  output sfts_pkg::sfts_axes_t GYRO_OUT,
  output sfts_pkg::sfts_axes_t ACCEL_OUT
);
  typedef enum logic {SFTS_IDLE, SFTS_EMIT} sfts_state_t;

  //------------------------------------------------------------------
  // declarations
  //------------------------------------------------------------------
  sfts_state_t state;
  sfts_state_t next_state;
  sfts_pkg::sfts_trate_t rate;
  sfts_pkg::sfts_frame_t packed_frame;
  sfts_pkg::sfts_set_t pick;
  sfts_pkg::sfts_axes_t snap_g;
  sfts_pkg::sfts_axes_t snap_a;
  sfts_pkg::sfts_axes_t src_g;
  sfts_pkg::sfts_axes_t src_a;
  logic [23:0] snap_ts;
  logic [15:0] snap_steps;
  logic [15:0] snap_temp;
  logic [2:0][5:0] reload;
  logic [15:0] temp_val;
  logic [2:0] due;
  logic [2:0] next_due;
  logic [2:0] new_due;
  logic [2:0][5:0] dcnt;
  logic [2:0] ev;
  logic [2:0] hit;
  logic third_on;
  logic take;
  logic accept;
  logic temp_tick;
  logic rd_temp;
  logic flag;
  logic [7:0] rd_mux;

  //------------------------------------------------------------------
  // temperature rate and sample tick
  //------------------------------------------------------------------
  sfts_temp_rate #(
    .DIV_LO(TEMP_DIV_LO),
    .DIV_MID(TEMP_DIV_MID),
    .DIV_MAX(TEMP_DIV_MAX)
  ) u_rate (
    .clk(REF_CLK),
    .rst(RESET),
    .cfg(CFG),
    .rate(rate),
    .tick(temp_tick)
  );

  assign TEMP_SENSOR_ON = rate != sfts_pkg::SFTS_TR_OFF;

  // latch the sample; value is two's complement, 16 counts per degree
  always_ff @(posedge REF_CLK) begin
    if (RESET) temp_val <= `SFTS_TEMP_RST;
    else if (temp_tick) temp_val <= TEMP_RAW;
  end

  //------------------------------------------------------------------
  // temperature register reads
  //------------------------------------------------------------------
  // a read of either byte clears the flag; a new sample wins
  assign rd_temp = REG_RD && (REG_ADDR == `SFTS_ADDR_TEMP_L ||
                              REG_ADDR == `SFTS_ADDR_TEMP_H);
  assign rd_mux = (REG_ADDR == `SFTS_ADDR_TEMP_L) ?
                    (CFG.byte_order_swap ? temp_val[15:8] :
                     temp_val[7:0]) :
                  (REG_ADDR == `SFTS_ADDR_TEMP_H) ?
                    (CFG.byte_order_swap ? temp_val[7:0] :
                     temp_val[15:8]) : `SFTS_RDATA_RST;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      flag <= 1'b0;
      REG_RDATA <= `SFTS_RDATA_RST;
    end else begin
      flag <= temp_tick || (flag && !rd_temp);
      if (REG_RD) REG_RDATA <= rd_mux;
    end
  end

  assign TEMP_SAMPLE_AVAILABLE = flag;
  assign SECOND_IRQ_PIN = flag && CFG.temp_flag_to_irq2;

  //------------------------------------------------------------------
  // self-test: output is the physical input plus the test force
  //------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      GYRO_OUT <= '0;
      ACCEL_OUT <= '0;
    end else begin
      ACCEL_OUT.x <= sfts_pkg::sfts_st_apply(ACCEL_RAW.x,
        CFG.accel_selftest_select, `SFTS_XL_ST_NEG);
      ACCEL_OUT.y <= sfts_pkg::sfts_st_apply(ACCEL_RAW.y,
        CFG.accel_selftest_select, `SFTS_XL_ST_NEG);
      ACCEL_OUT.z <= sfts_pkg::sfts_st_apply(ACCEL_RAW.z,
        CFG.accel_selftest_select, `SFTS_XL_ST_NEG);
      GYRO_OUT.x <= sfts_pkg::sfts_st_apply(GYRO_RAW.x,
        CFG.gyro_selftest_select, `SFTS_G_ST_NEG);
      GYRO_OUT.y <= sfts_pkg::sfts_st_apply(GYRO_RAW.y,
        CFG.gyro_selftest_select, `SFTS_G_ST_NEG);
      GYRO_OUT.z <= sfts_pkg::sfts_st_apply(GYRO_RAW.z,
        CFG.gyro_selftest_select, `SFTS_G_ST_NEG);
    end
  end

  //------------------------------------------------------------------
  // data-set events and decimation
  //------------------------------------------------------------------
  // counter reload for a decimation code; an unstored set stays at zero
  // so that it stores on its first event once the host enables it
  function automatic logic [5:0] dec_reload(input logic [2:0] code);
    if (code == `SFTS_DEC_OFF) dec_reload = 6'h00;
    else dec_reload = sfts_pkg::sfts_dec_factor(code) - 6'h01;
  endfunction

  assign reload[0] = dec_reload(CFG.gyro_set_decimation);
  assign reload[1] = dec_reload(CFG.accel_set_decimation);
  assign reload[2] = dec_reload(CFG.third_set_decimation);

  // third set holds stamp/steps, else temperature when enabled
  assign third_on = CFG.stamp_steps_store_en || CFG.temp_store_en;
  assign ev[0] = FIFO_TRIG;
  assign ev[1] = FIFO_TRIG && !CFG.high_only;
  assign ev[2] = third_on && ((CFG.stamp_steps_store_en &&
                 CFG.step_trigger_select) ? STEP_DET : FIFO_TRIG);
  assign hit[0] = dcnt[0] == 6'h00 &&
                  CFG.gyro_set_decimation != `SFTS_DEC_OFF;
  assign hit[1] = dcnt[1] == 6'h00 &&
                  CFG.accel_set_decimation != `SFTS_DEC_OFF;
  assign hit[2] = dcnt[2] == 6'h00 &&
                  CFG.third_set_decimation != `SFTS_DEC_OFF;
  assign new_due = ev & hit;
  assign take = state == SFTS_IDLE && new_due != 3'h0;

  // each set counts its own events; events while busy are dropped
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < 3; i++) begin
      if (RESET) dcnt[i] <= 6'h00;
      else if (state == SFTS_IDLE && ev[i])
        dcnt[i] <= (dcnt[i] == 6'h00) ? reload[i] : dcnt[i] - 6'h01;
    end
  end

  //------------------------------------------------------------------
  // frame sequencer: emits due sets in order one, two, three
  //------------------------------------------------------------------
  assign accept = state == SFTS_EMIT && FRAME_READY;
  assign FRAME_VALID = state == SFTS_EMIT;

  always_comb begin
    next_due = due;
    next_state = state;
    unique case (state)
      SFTS_IDLE: begin
        if (take) begin
          next_due = new_due;
          next_state = SFTS_EMIT;
        end
      end
      SFTS_EMIT: begin
        if (accept) begin
          next_due = due & ~(3'h1 << FRAME.set);
          if (next_due == 3'h0) next_state = SFTS_IDLE;
        end
      end
    endcase
  end

  // packer reads live inputs when idle, the snapshot when emitting
  assign src_g = (state == SFTS_IDLE) ? GYRO_OUT : snap_g;
  assign src_a = (state == SFTS_IDLE) ? ACCEL_OUT : snap_a;
  assign pick = sfts_pkg::sfts_first_due(next_due);

  sfts_frame_pack u_pack (
    .set_sel(pick),
    .cfg(CFG),
    .gyro(src_g),
    .accel(src_a),
    .stamp(state == SFTS_IDLE ? TIME_STAMP : snap_ts),
    .steps(state == SFTS_IDLE ? STEP_COUNT : snap_steps),
    .temp(state == SFTS_IDLE ? temp_val : snap_temp),
    .frame(packed_frame)
  );

  // state, due mask and snapshot of the triggering sample
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state <= SFTS_IDLE;
      due <= 3'h0;
      FRAME <= '0;
    end else begin
      state <= next_state;
      due <= next_due;
      if (take || (accept && next_due != 3'h0)) FRAME <= packed_frame;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (take) begin
      snap_g <= GYRO_OUT;
      snap_a <= ACCEL_OUT;
      snap_ts <= TIME_STAMP;
      snap_steps <= STEP_COUNT;
      snap_temp <= temp_val;
    end
  end

  //------------------------------------------------------------------
  // checks
  //------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_step_ev;
    state == SFTS_IDLE && CFG.stamp_steps_store_en &&
    CFG.step_trigger_select && STEP_DET && hit[2];
  endsequence
  sequence s_due3;
    state == SFTS_EMIT && due[2];
  endsequence

  a_high_byte_order: assert property (FRAME_VALID && CFG.high_only &&
    FRAME.set == sfts_pkg::SFTS_SET1 |-> FRAME.b[0] == snap_g.x[15:8] &&
    FRAME.b[1] == snap_a.x[15:8] && FRAME.b[5] == snap_a.z[15:8])
    else $error("high byte frame order wrong");
  a_set2_unused: assert property (CFG.high_only && take |=>
    !due[1]) else $error("second set used in high byte mode");
  a_stamp_layout: assert property (FRAME_VALID &&
    FRAME.set == sfts_pkg::SFTS_SET3 && CFG.stamp_steps_store_en |->
    FRAME.b[0] == snap_ts[15:8] && FRAME.b[2] == 8'h00 &&
    FRAME.b[5] == snap_steps[15:8])
    else $error("stamp frame layout wrong");
  a_step_frame: assert property (s_step_ev |=> s_due3)
    else $error("step did not schedule third set");
  a_temp_layout: assert property (FRAME_VALID &&
    FRAME.set == sfts_pkg::SFTS_SET3 && !CFG.stamp_steps_store_en |->
    FRAME.b[2] == snap_temp[7:0] && FRAME.b[3] == snap_temp[15:8] &&
    FRAME.b[0] == 8'h00) else $error("temperature frame layout wrong");
  a_temp_off: assert property (CFG.accel_odr == `SFTS_ODR_PD &&
    CFG.gyro_odr == `SFTS_ODR_PD |-> !temp_tick && !TEMP_SENSOR_ON)
    else $error("temperature sensor on while both powered down");
  a_flag_irq: assert property (temp_tick ##1 CFG.temp_flag_to_irq2 |->
    TEMP_SAMPLE_AVAILABLE && SECOND_IRQ_PIN)
    else $error("temperature flag not raised");
  a_swap_read: assert property (REG_RD && CFG.byte_order_swap &&
    REG_ADDR == `SFTS_ADDR_TEMP_H |=> REG_RDATA == $past(temp_val[7:0]))
    else $error("swapped high byte read wrong");
  a_xl_selftest: assert property (CFG.accel_selftest_select ==
    `SFTS_ST_POS |=> ACCEL_OUT.x == $past(ACCEL_RAW.x) + `SFTS_ST_FORCE)
    else $error("self-test sum wrong");
endmodule // sfts_top

// ===== verif/sfts_frame_sink.sv
// frame consumer model standing at the fifo write side of the block
`timescale 1ns/10ps
module sfts_frame_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic valid,
  input wire sfts_pkg::sfts_frame_t frame,
  input wire logic slow,
  output logic ready
);
  //----------------------------------------
  // acceptance and capture
  //----------------------------------------
  logic [2:0] wait_cnt;
  int count;
  sfts_pkg::sfts_frame_t last;
  sfts_pkg::sfts_frame_t prev;
  // ready only while a frame is offered; slow mode stalls each frame
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_cnt <= 3'h0;
      ready <= 1'b0;
      count <= 0;
      last <= '0;
      prev <= '0;
    end else if (valid && ready) begin
      count <= count + 1;
      prev <= last;
      last <= frame;
      ready <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (valid) begin
      wait_cnt <= wait_cnt + 3'h1;
      ready <= !slow || (wait_cnt == 3'h3);
    end else begin
      ready <= 1'b0;
    end
  end
endmodule // sfts_frame_sink

// ===== verif/sfts_top_tb_top.sv
// testbench of the fifo data-set, temperature and self-test block
`timescale 1ns/10ps
`include "sfts_consts.svh"
`define SFTS_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module sfts_top_tb_top;
  //----------------------------------------
  // signals
  //----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  sfts_pkg::sfts_cfg_t cfg = '0;
  sfts_pkg::sfts_axes_t gyro_raw = '0;
  sfts_pkg::sfts_axes_t accel_raw = '0;
  logic [15:0] temp_raw = 16'hFE70;
  logic [23:0] stamp = 24'hABCDEF;
  logic [15:0] steps = 16'h1234;
  logic fifo_trig = 1'b0;
  logic step_det = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reg_rdata;
  logic frame_valid, frame_ready, temp_on, temp_avail, irq2;
  sfts_pkg::sfts_frame_t frame;
  sfts_pkg::sfts_axes_t gyro_out, accel_out;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] d;
  int t0, t1, n;
  //----------------------------------------
  // clock, design and partner
  //----------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  sfts_top #(.TEMP_DIV_LO(40), .TEMP_DIV_MID(20), .TEMP_DIV_MAX(10))
    sfts_top_i (.REF_CLK(clk), .RESET(rst), .CFG(cfg),
    .GYRO_RAW(gyro_raw), .ACCEL_RAW(accel_raw), .TEMP_RAW(temp_raw),
    .TIME_STAMP(stamp), .STEP_COUNT(steps), .FIFO_TRIG(fifo_trig),
    .STEP_DET(step_det), .REG_ADDR(reg_addr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .FRAME_VALID(frame_valid),
    .FRAME_READY(frame_ready), .FRAME(frame), .TEMP_SENSOR_ON(temp_on),
    .TEMP_SAMPLE_AVAILABLE(temp_avail), .SECOND_IRQ_PIN(irq2),
    .GYRO_OUT(gyro_out), .ACCEL_OUT(accel_out));
  sfts_frame_sink sfts_frame_sink_i (.clk(clk), .rst(rst),
    .valid(frame_valid), .frame(frame), .slow(slow), .ready(frame_ready));
  //----------------------------------------
  // tasks
  //----------------------------------------
  // register read: request held over one rising edge, data after it
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask
  // waits for a new sample, checks its routing, then clears the flag
  task automatic sample(output int t);
    for (int i = 0; i < 300 && temp_avail !== 1'b1; i++) @(negedge clk);
    t = cyc;
    `SFTS_CHK("sample seen", 1'b1, temp_avail)
    `SFTS_CHK("irq2", cfg.temp_flag_to_irq2, irq2)
    rd(8'h20, d);
    `SFTS_CHK("flag clear", 1'b0, temp_avail)
  endtask
  // sample spacing in clock cycles for one sensor setting
  task automatic rate_case(input logic [3:0] ao, input logic al,
      input logic [3:0] go, input logic gl, input int exp_div);
    @(negedge clk);
    cfg.accel_odr = ao;
    cfg.accel_low_power = al;
    cfg.gyro_odr = go;
    cfg.gyro_low_power = gl;
    sample(t0);
    sample(t0);
    sample(t1);
    `SFTS_CHK("temp period", exp_div, t1 - t0)
  endtask
  // one trigger pulse, then wait until offered frames are taken
  task automatic fire(input logic step);
    @(negedge clk);
    if (step) step_det = 1'b1;
    else fifo_trig = 1'b1;
    @(negedge clk);
    step_det = 1'b0;
    fifo_trig = 1'b0;
    for (int i = 0; i < 60 && frame_valid !== 1'b0; i++) @(negedge clk);
    `SFTS_CHK("frames drained", 1'b0, frame_valid)
  endtask
  // self-test code pair and the offset expected on every axis
  task automatic st_case(input logic [1:0] a, input logic [1:0] g,
      input logic [15:0] ad, input logic [15:0] gd);
    @(negedge clk);
    cfg.accel_selftest_select = a;
    cfg.gyro_selftest_select = g;
    repeat (2) @(negedge clk);
    `SFTS_CHK("accel st", {accel_raw.x + ad, accel_raw.y + ad,
      accel_raw.z + ad}, accel_out)
    `SFTS_CHK("gyro st", {gyro_raw.x + gd, gyro_raw.y + gd,
      gyro_raw.z + gd}, gyro_out)
  endtask
  task automatic test_end(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //----------------------------------------
  // watchdog
  //----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("BAD watchdog exp done got hang");
    test_done();
  end
  //----------------------------------------
  // tests
  //----------------------------------------
  initial begin
    gyro_raw = {16'h1122, 16'h3344, 16'h5566};
    accel_raw = {16'h7788, 16'h99AA, 16'hBBCC};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    `SFTS_CHK("rdata rst", 8'h00, reg_rdata)
    `SFTS_CHK("valid rst", 1'b0, frame_valid)
    rd(8'h22, d);
    `SFTS_CHK("unmapped", 8'h00, d)
    `SFTS_CHK("sensor off", 1'b0, temp_on)
    test_end("reset");
    cfg.temp_flag_to_irq2 = 1'b1;
    rate_case(4'h1, 1'b0, 4'h0, 1'b0, 40);
    rate_case(4'h2, 1'b1, 4'h0, 1'b0, 20);
    cfg.temp_flag_to_irq2 = 1'b0;
    rate_case(4'h2, 1'b0, 4'h0, 1'b0, 10);
    rate_case(4'h0, 1'b0, 4'h1, 1'b1, 40);
    rate_case(4'h0, 1'b0, 4'h2, 1'b1, 20);
    rate_case(4'h0, 1'b0, 4'h1, 1'b0, 10);
    rate_case(4'h1, 1'b0, 4'h1, 1'b0, 10);
    rate_case(4'h2, 1'b0, 4'h1, 1'b1, 20);
    `SFTS_CHK("sensor on", 1'b1, temp_on)
    test_end("rates");
    rd(8'h21, d);
    `SFTS_CHK("temp hi", 8'hFE, d)
    rd(8'h20, d);
    `SFTS_CHK("temp lo", 8'h70, d)
    cfg.byte_order_swap = 1'b1;
    rd(8'h21, d);
    `SFTS_CHK("swap hi", 8'h70, d)
    rd(8'h20, d);
    `SFTS_CHK("swap lo", 8'hFE, d)
    cfg.byte_order_swap = 1'b0;
    temp_raw = 16'h0190;
    sample(t0);
    sample(t0);
    rd(8'h21, d);
    `SFTS_CHK("temp 50 hi", 8'h01, d)
    rd(8'h20, d);
    `SFTS_CHK("temp 50 lo", 8'h90, d)
    test_end("temperature");
    // temperature logging: sensor on, decimation, store enable, rate
    cfg.third_set_decimation = 3'h1;
    cfg.temp_store_en = 1'b1;
    fire(1'b0);
    `SFTS_CHK("temp frame", {sfts_pkg::SFTS_SET3, 16'h0000, 16'h0190,
      16'h0000}, sfts_frame_sink_i.last)
    cfg.third_set_decimation = 3'h2;
    n = sfts_frame_sink_i.count;
    repeat (4) fire(1'b0);
    `SFTS_CHK("dec count", 2, sfts_frame_sink_i.count - n)
    test_end("temp frames");
    // stamp logging order: decimation, store enable, trigger select
    cfg.high_only = 1'b1;
    cfg.gyro_set_decimation = 3'h1;
    cfg.accel_set_decimation = 3'h0;
    cfg.third_set_decimation = 3'h1;
    cfg.stamp_steps_store_en = 1'b1;
    cfg.step_trigger_select = 1'b0;
    slow = 1'b1;
    n = sfts_frame_sink_i.count;
    fire(1'b0);
    `SFTS_CHK("hi count", 2, sfts_frame_sink_i.count - n)
    `SFTS_CHK("hi frame", {sfts_pkg::SFTS_SET1, 48'hBB55_9933_7711},
      sfts_frame_sink_i.prev)
    `SFTS_CHK("stamp frame", {sfts_pkg::SFTS_SET3, 48'h1234_EF00_ABCD},
      sfts_frame_sink_i.last)
    cfg.high_only = 1'b0;
    cfg.gyro_set_decimation = 3'h0;
    cfg.step_trigger_select = 1'b1;
    slow = 1'b0;
    steps = 16'h1235;
    n = sfts_frame_sink_i.count;
    fire(1'b1);
    `SFTS_CHK("step frame", {sfts_pkg::SFTS_SET3, 48'h1235_EF00_ABCD},
      sfts_frame_sink_i.last)
    fire(1'b0);
    `SFTS_CHK("step count", 1, sfts_frame_sink_i.count - n)
    test_end("stamp frames");
    st_case(2'h0, 2'h0, 16'h0000, 16'h0000);
    st_case(2'h1, 2'h1, `SFTS_ST_FORCE, `SFTS_ST_FORCE);
    st_case(2'h2, 2'h3, 16'hFF00, 16'hFF00);
    st_case(2'h3, 2'h2, 16'h0000, 16'h0000);
    test_end("self-test");
    test_done();
  end
endmodule // sfts_top_tb_top
